// ===== verilog/ecpc_pkg.sv
// package for the echo canceller pin control block
// assumes one 25 MHz core clock; the eleven cfg, control and state select pins are resynchronised by the top module
package ecpc_pkg;
    // canceller functional states, pin pair value order
    typedef enum logic [1:0] {
        ECPC_MUTE = 2'h0,   // output muted
        ECPC_BYPASS = 2'h1,   // datapath transparent
        ECPC_ADAPT_OFF = 2'h2,   // cancel, frozen filter
        ECPC_ADAPT_ON = 2'h3    // cancel and adapt
    } ecpc_fstate_type;

    // per-canceller controls handed to the datapath
    typedef struct packed {
        logic nlp_en;          // nonlinear processor enabled
        logic rev_only;        // trigger only on phase-reversed tone
        logic a_law;           // 1 a-law, 0 mu-law
        logic itu_code;        // 1 g.711 coding, 0 sign-magnitude
        ecpc_fstate_type fstate; // functional state
    } ecpc_chan_ctl_type;

    // controller-mode register override bits
    typedef struct packed {
        logic nonlinear_proc_off_bit; // disables both processors
        logic phase_rev_off_bit;      // drops reversal qualification
        ecpc_fstate_type fstate_a;    // state of canceller a
        ecpc_fstate_type fstate_b;    // state of canceller b
    } ecpc_reg_ovr_type;

    // reset values and timing
    localparam int ECPC_SYNC_STAGES = 3;        // pin synchroniser depth
    localparam int ECPC_SLOT_AFTER = 4;         // frame pulse after this slot
    localparam int ECPC_SLOT_BITS = 8;          // bits per channel time slot
    localparam logic ECPC_TONE_IDLE = 1'b1;     // tone outputs idle high
    localparam logic ECPC_FRAME_IDLE = 1'b1;    // delayed frame pulse idle level
    localparam logic ECPC_CFG_CTRL = 1'b0;      // both cfg pins at this level
endpackage : ecpc_pkg

// ===== verilog/ecpc_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes async inputs; output changes once stages two and three agree
`timescale 1ns/1ps
module ecpc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    import ecpc_pkg::*;

    // a zero-width bus would leave the level register empty
    if (WIDTH < 1) begin : g_bad_width
        $error("ecpc_sync needs at least one bit");
    end

    // all state in one struct
    typedef struct packed {
        logic [WIDTH-1:0] s1; // first stage, read only by s2
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lv; // filtered level
    } ecpc_sync_st_type;

    ecpc_sync_st_type st_q;
    ecpc_sync_st_type st_d;

    // per bit: accept a change only when two later stages agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lv[i] = st_q.s3[i];
            end
        end
    end

    // register the state
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= {INIT, INIT, INIT, INIT};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lv;
endmodule : ecpc_sync

// ===== verilog/ecpc_top.sv
// pin control and mode decode for a dual voice echo canceller
// assumes the serial port engine, tone detectors and frame timing are elsewhere
`timescale 1ns/1ps
module ecpc_top (
    core_clk,
    nrst,
    cfg_pin_one,
    cfg_pin_two,
    nonlinear_proc_ctl,
    reversal_detect_sel,
    law_sel,
    code_fmt_sel,
    power_down_n,
    state_sel_b,
    state_sel_a,
    port_data_io_in,
    port_data_io_out,
    port_data_io_oe,
    port_rd_data,
    port_rd_phase,
    reg_ovr,
    tone_det_a,
    tone_det_b,
    frame_bus_mode,
    frame_in_n,
    slot_bit_en,
    tone_hit_a_n,
    tone_hit_b_n,
    frame_pulse_delayed_out,
    ctl_a,
    ctl_b,
    controller_mode,
    port_sclk,
    port_cs_n,
    port_sdi,
    core_reset_n,
    standby
);
    import ecpc_pkg::*;

    input wire logic core_clk;                 // 25 MHz core clock
    input wire logic nrst;                     // async reset, active low
    input wire logic cfg_pin_one;              // configuration pin
    input wire logic cfg_pin_two;              // configuration pin
    input wire logic nonlinear_proc_ctl;       // processor enable pin
    input wire logic reversal_detect_sel;      // reversal qualification pin
    input wire logic law_sel;                  // companding law pin
    input wire logic code_fmt_sel;             // code format pin
    input wire logic power_down_n;             // power-down pin, active low
    input wire logic [1:0] state_sel_b;        // [1] clock, [0] chip select in ctl mode
    input wire logic [1:0] state_sel_a;        // [1] port_data_in, [0] data io in
    input wire logic port_data_io_in;          // level seen on the io pin
    output logic port_data_io_out;             // driven level of io pin
    output logic port_data_io_oe;              // high while driving io pin
    input wire logic port_rd_data;             // read bit from port engine
    input wire logic port_rd_phase;            // engine is in a read data phase
    input wire ecpc_pkg::ecpc_reg_ovr_type reg_ovr; // control register overrides
    input wire logic tone_det_a;               // canceller a tone detected
    input wire logic tone_det_b;               // canceller b tone detected
    input wire logic frame_bus_mode;           // 1 frame-pulse bus, 0 strobe mode
    input wire logic frame_in_n;               // synchronised frame pulse, low active
    input wire logic slot_bit_en;              // one pulse per bit time
    output logic tone_hit_a_n;                 // tone detect a, active low
    output logic tone_hit_b_n;                 // tone detect b, active low
    output logic frame_pulse_delayed_out;      // delayed frame pulse, low active
    output ecpc_pkg::ecpc_chan_ctl_type ctl_a; // controls for canceller a
    output ecpc_pkg::ecpc_chan_ctl_type ctl_b; // controls for canceller b
    output logic controller_mode;              // serial port mode active
    output logic port_sclk;                    // serial clock to port engine
    output logic port_cs_n;                    // chip select to port engine
    output logic port_sdi;                     // serial data in to port engine
    output logic core_reset_n;                 // datapath reset, active low
    output logic standby;                      // low power request

    localparam int SLOT_CNT_W = $clog2(ECPC_SLOT_AFTER * ECPC_SLOT_BITS + 1);
    localparam logic [SLOT_CNT_W-1:0] SLOT_END = SLOT_CNT_W'(ECPC_SLOT_AFTER * ECPC_SLOT_BITS);

    // pin inputs collected for one synchroniser
    localparam int PIN_W = 11;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    assign pin_raw = {cfg_pin_one, cfg_pin_two, nonlinear_proc_ctl, reversal_detect_sel,
                      law_sel, code_fmt_sel, power_down_n, state_sel_b, state_sel_a};

    // pins synchronised; power-down idles high so no standby glitch at reset
    // cfg pins and chip select idle high: no controller mode or select glitch
    ecpc_sync #(.WIDTH(PIN_W), .INIT(PIN_W'(11'h634))) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin(pin_raw),
        .level(pin_s)
    );

    // readable names for synchronised pins
    logic s_cfg1, s_cfg2, s_nlp, s_rev, s_law, s_fmt, s_pwr;
    logic [1:0] s_sb;
    logic [1:0] s_sa;
    assign {s_cfg1, s_cfg2, s_nlp, s_rev, s_law, s_fmt, s_pwr, s_sb, s_sa} = pin_s;

    // all module state
    typedef struct packed {
        logic ctl_mode;
        ecpc_chan_ctl_type a;
        ecpc_chan_ctl_type b;
        logic td_a_n;
        logic td_b_n;
        logic fp_out;
        logic fp_armed;
        logic [SLOT_CNT_W-1:0] slot_cnt;
        logic sclk;
        logic cs_n;
        logic sdi;
        logic io_out;
        logic io_oe;
        logic rst_n;
        logic stby;
    } ecpc_st_type;

    ecpc_st_type st_q;
    ecpc_st_type st_d;

    // next state
    always_comb begin
        st_d = st_q;
        // serial port only when both cfg pins low
        st_d.ctl_mode = (s_cfg1 == ECPC_CFG_CTRL) && (s_cfg2 == ECPC_CFG_CTRL);
        // power-down holds the datapath in reset and standby
        st_d.rst_n = s_pwr;
        st_d.stby = !s_pwr;
        // law and format act in both modes
        st_d.a.a_law = s_law;
        st_d.b.a_law = s_law;
        st_d.a.itu_code = s_fmt;
        st_d.b.itu_code = s_fmt;
        if (st_q.ctl_mode) begin
            // pins ignored, register bits steer
            st_d.a.nlp_en = !reg_ovr.nonlinear_proc_off_bit;
            st_d.b.nlp_en = !reg_ovr.nonlinear_proc_off_bit;
            st_d.a.rev_only = !reg_ovr.phase_rev_off_bit;
            st_d.b.rev_only = !reg_ovr.phase_rev_off_bit;
            st_d.a.fstate = reg_ovr.fstate_a;
            st_d.b.fstate = reg_ovr.fstate_b;
            // state pins reused as the serial port
            st_d.sclk = s_sb[1];
            st_d.cs_n = s_sb[0];
            st_d.sdi = s_sa[1];
        end else begin
            st_d.a.nlp_en = s_nlp;
            st_d.b.nlp_en = s_nlp;
            st_d.a.rev_only = s_rev;
            st_d.b.rev_only = s_rev;
            st_d.a.fstate = ecpc_fstate_type'(s_sa);
            st_d.b.fstate = ecpc_fstate_type'(s_sb);
            // port held deselected so the engine sees no traffic
            st_d.sclk = 1'b0;
            st_d.cs_n = 1'b1;
            st_d.sdi = 1'b0;
        end
        // data io drives only in a read phase under chip select
        st_d.io_oe = st_q.ctl_mode && !s_sb[0] && port_rd_phase;
        st_d.io_out = port_rd_data;
        // tone outputs follow detectors, released when detector clears
        st_d.td_a_n = !tone_det_a;
        st_d.td_b_n = !tone_det_b;
        // delayed frame: count bit times after the frame pulse
        if (!frame_bus_mode) begin
            st_d.fp_out = 1'b0;
            st_d.fp_armed = 1'b0;
            st_d.slot_cnt = '0;
        end else begin
            st_d.fp_out = ECPC_FRAME_IDLE;
            if (!frame_in_n) begin
                st_d.fp_armed = 1'b1;
                st_d.slot_cnt = '0;
            end else if (st_q.fp_armed && slot_bit_en) begin
                if (st_q.slot_cnt == SLOT_END - SLOT_CNT_W'(1)) begin
                    // pulse one bit time long after slot four
                    st_d.fp_armed = 1'b0;
                    st_d.slot_cnt = '0;
                end else begin
                    st_d.slot_cnt = st_q.slot_cnt + SLOT_CNT_W'(1);
                end
            end
            if (st_q.fp_armed && st_q.slot_cnt == SLOT_END - SLOT_CNT_W'(1)) begin
                st_d.fp_out = 1'b0;
            end
        end
        // standby clears the detect outputs as the datapath is reset
        if (!s_pwr) begin
            st_d.td_a_n = ECPC_TONE_IDLE;
            st_d.td_b_n = ECPC_TONE_IDLE;
            st_d.io_oe = 1'b0;
        end
    end

    // register state; reset pulls datapath into reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.td_a_n <= ECPC_TONE_IDLE;
            st_q.td_b_n <= ECPC_TONE_IDLE;
            st_q.cs_n <= 1'b1;
            st_q.stby <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops
    assign controller_mode = st_q.ctl_mode;
    assign ctl_a = st_q.a;
    assign ctl_b = st_q.b;
    assign tone_hit_a_n = st_q.td_a_n;
    assign tone_hit_b_n = st_q.td_b_n;
    assign frame_pulse_delayed_out = st_q.fp_out;
    assign port_sclk = st_q.sclk;
    assign port_cs_n = st_q.cs_n;
    assign port_sdi = st_q.sdi;
    assign port_data_io_out = st_q.io_out;
    assign port_data_io_oe = st_q.io_oe;
    assign core_reset_n = st_q.rst_n;
    assign standby = st_q.stby;

    // assertions
    property p_nlp_pin;
        @(posedge core_clk) disable iff (!nrst)
        !st_q.ctl_mode |=> ctl_a.nlp_en == $past(s_nlp) && ctl_b.nlp_en == $past(s_nlp);
    endproperty
    a_nlp_pin: assert property (p_nlp_pin) else $error("nlp pin not followed");

    property p_nlp_reg;
        @(posedge core_clk) disable iff (!nrst)
        st_q.ctl_mode |=> ctl_a.nlp_en != $past(reg_ovr.nonlinear_proc_off_bit);
    endproperty
    a_nlp_reg: assert property (p_nlp_reg) else $error("nlp off bit not followed");

    property p_rev;
        @(posedge core_clk) disable iff (!nrst)
        !st_q.ctl_mode |=> ctl_b.rev_only == $past(s_rev);
    endproperty
    a_rev: assert property (p_rev) else $error("reversal pin not followed");

    property p_rev_reg;
        @(posedge core_clk) disable iff (!nrst)
        st_q.ctl_mode |=> ctl_a.rev_only != $past(reg_ovr.phase_rev_off_bit);
    endproperty
    a_rev_reg: assert property (p_rev_reg) else $error("phase off bit not followed");

    property p_law;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |=> ctl_a.a_law == $past(s_law) && ctl_b.itu_code == $past(s_fmt);
    endproperty
    a_law: assert property (p_law) else $error("law or format wrong");

    property p_pwr;
        @(posedge core_clk) disable iff (!nrst)
        !s_pwr |=> !core_reset_n && standby && tone_hit_a_n;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power-down not applied");

    property p_tone;
        @(posedge core_clk) disable iff (!nrst)
        tone_det_a && s_pwr |=> !tone_hit_a_n;
    endproperty
    a_tone: assert property (p_tone) else $error("tone a not flagged");

    property p_mode;
        @(posedge core_clk) disable iff (!nrst)
        s_cfg1 |=> !controller_mode;
    endproperty
    a_mode: assert property (p_mode) else $error("controller mode with cfg high");

    property p_io;
        @(posedge core_clk) disable iff (!nrst)
        !port_rd_phase |=> !port_data_io_oe;
    endproperty
    a_io: assert property (p_io) else $error("io driven outside read");

    property p_strobe;
        @(posedge core_clk) disable iff (!nrst)
        !frame_bus_mode |=> !frame_pulse_delayed_out;
    endproperty
    a_strobe: assert property (p_strobe) else $error("delayed frame not low");
endmodule : ecpc_top

// ===== tb/ecpc_host_model.sv
// host microcontroller model on the state select and serial port pins
// assumes the bench calls its tasks just after a falling core clock edge
`timescale 1ns/1ps
module ecpc_host_model (
    input wire logic core_clk,
    input wire logic io_out,
    input wire logic io_oe,
    output logic [1:0] sel_b,
    output logic [1:0] sel_a,
    output logic io_wire
);
    logic din_q; // separate receive data line
    logic drv_en; // host drives the shared line
    logic drv_val; // host level on the shared line
    logic last_q; // last resolved shared line level

    // straps at time zero, chip select idle high
    initial begin
        sel_b = 2'h1;
        din_q = 1'b0;
        drv_en = 1'b1;
        drv_val = 1'b0;
        last_q = 1'b0;
    end

    // released line shows the inverse of its last level, so no stale copy passes
    assign io_wire = io_oe ? io_out : (drv_en ? drv_val : ~last_q);
    assign sel_a = {din_q, io_wire};

    // remember the last driven level; a released line must not toggle
    always @(posedge core_clk) begin
        if (io_oe || drv_en) begin
            last_q <= io_wire;
        end
    end

    // board straps on all four state pins
    task automatic strap(input logic [1:0] b, input logic [1:0] a);
        sel_b = b;
        din_q = a[1];
        drv_val = a[0];
        drv_en = 1'b1;
    endtask : strap

    // port levels; a read releases the shared line to the device
    task automatic port(input logic cs_n, input logic sclk, input logic mosi, input logic rd);
        sel_b = {sclk, cs_n};
        din_q = mosi;
        drv_en = ~rd;
    endtask : port
endmodule : ecpc_host_model

// ===== tb/echo_canceller_pin_control_tb.sv
// self-checking bench for the echo canceller pin control block
// assumes pins settle 5 edges after a change, same-clock inputs 1 edge
`timescale 1ns/1ps
module echo_canceller_pin_control_tb;
    import ecpc_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_pin_one = 1'b1, cfg_pin_two = 1'b1;
    logic nonlinear_proc_ctl = 1'b1, reversal_detect_sel = 1'b0, law_sel = 1'b0;
    logic code_fmt_sel = 1'b0, power_down_n = 1'b1, port_rd_data = 1'b0, port_rd_phase = 1'b0;
    logic tone_det_a = 1'b0, tone_det_b = 1'b0, frame_bus_mode = 1'b1;
    logic frame_in_n = 1'b1, slot_bit_en = 1'b0;
    ecpc_reg_ovr_type reg_ovr = '0; // register overrides
    logic [1:0] state_sel_b, state_sel_a, v;
    logic port_data_io_in, port_data_io_out, port_data_io_oe, tone_hit_a_n, tone_hit_b_n;
    logic frame_pulse_delayed_out, controller_mode, port_sclk, port_cs_n, port_sdi;
    logic core_reset_n, standby;
    ecpc_chan_ctl_type ctl_a, ctl_b;
    int error_cnt = 0, checked = 0, i, m;

    ecpc_top uut (.core_clk, .nrst, .cfg_pin_one, .cfg_pin_two, .nonlinear_proc_ctl,
        .reversal_detect_sel, .law_sel, .code_fmt_sel, .power_down_n, .state_sel_b,
        .state_sel_a, .port_data_io_in, .port_data_io_out, .port_data_io_oe, .port_rd_data,
        .port_rd_phase, .reg_ovr, .tone_det_a, .tone_det_b, .frame_bus_mode, .frame_in_n,
        .slot_bit_en, .tone_hit_a_n, .tone_hit_b_n, .frame_pulse_delayed_out, .ctl_a, .ctl_b,
        .controller_mode, .port_sclk, .port_cs_n, .port_sdi, .core_reset_n, .standby);

    ecpc_host_model host (.core_clk, .io_out(port_data_io_out), .io_oe(port_data_io_oe),
        .sel_b(state_sel_b), .sel_a(state_sel_a), .io_wire(port_data_io_in));

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    // single-bit comparison
    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    // canceller control struct comparison
    task automatic chk_ctl(input string n, input ecpc_chan_ctl_type e, input ecpc_chan_ctl_type g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_ctl

    // pins need sync plus filter plus output register
    task automatic settle();
        repeat (6) @(negedge core_clk);
    endtask : settle

    // expected controls, field order of the package struct
    function automatic ecpc_chan_ctl_type exp_ctl(input logic n, input logic r, input logic l,
        input logic f, input logic [1:0] s);
        exp_ctl = {n, r, l, f, s};
    endfunction : exp_ctl

    // verdict, reached from the tests and from the watchdog
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // tests run well under 600 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (2) @(negedge core_clk);
        chk_bit("core_reset_n", 1'b0, core_reset_n);
        chk_bit("standby", 1'b1, standby);
        chk_bit("tone_hit_a_n", ECPC_TONE_IDLE, tone_hit_a_n);
        nrst = 1'b1;
        // pin mode: each cfg combination other than both low
        for (i = 0; i < 4; i++) begin
            v = i[1:0];
            cfg_pin_one = (i != 2);
            cfg_pin_two = v[1];
            nonlinear_proc_ctl = v[0];
            reversal_detect_sel = v[1];
            law_sel = ~v[0];
            code_fmt_sel = ^v;
            reg_ovr = {~v[0], ~v[1], ~v, v};
            host.strap(v, ~v);
            settle();
            chk_bit("controller_mode", 1'b0, controller_mode);
            chk_ctl("ctl_a", exp_ctl(v[0], v[1], ~v[0], ^v, ~v), ctl_a);
            chk_ctl("ctl_b", exp_ctl(v[0], v[1], ~v[0], ^v, v), ctl_b);
            chk_bit("port_cs_n", 1'b1, port_cs_n);
        end
        // controller mode: processor and reversal pins ignored, register bits rule
        cfg_pin_one = 1'b0;
        cfg_pin_two = 1'b0;
        for (i = 0; i < 4; i++) begin
            v = i[1:0];
            nonlinear_proc_ctl = v[0];
            reversal_detect_sel = v[1];
            law_sel = ~v[0];
            code_fmt_sel = ^v;
            port_rd_phase = v[0];
            reg_ovr = {v[0], v[1], v, ~v};
            host.port(1'b1, v[1], v[0], 1'b0);
            settle();
            chk_bit("controller_mode", 1'b1, controller_mode);
            chk_ctl("ctl_a", exp_ctl(~v[0], ~v[1], ~v[0], ^v, v), ctl_a);
            chk_ctl("ctl_b", exp_ctl(~v[0], ~v[1], ~v[0], ^v, ~v), ctl_b);
            chk_bit("port_sclk", v[1], port_sclk);
            chk_bit("port_sdi", v[0], port_sdi);
            chk_bit("port_data_io_oe", 1'b0, port_data_io_oe);
        end
        // read phase under chip select drives the shared line
        host.port(1'b0, 1'b0, 1'b0, 1'b1);
        port_rd_phase = 1'b1;
        port_rd_data = 1'b1;
        settle();
        chk_bit("port_cs_n", 1'b0, port_cs_n);
        chk_bit("port_data_io_oe", 1'b1, port_data_io_oe);
        chk_bit("port_data_io_in", 1'b1, port_data_io_in);
        port_rd_data = 1'b0;
        @(negedge core_clk);
        chk_bit("port_data_io_in", 1'b0, port_data_io_in);
        port_rd_phase = 1'b0;
        @(negedge core_clk);
        chk_bit("port_data_io_oe", 1'b0, port_data_io_oe);
        host.port(1'b1, 1'b0, 1'b0, 1'b0);
        // tone outputs follow the detectors one edge later
        tone_det_a = 1'b1;
        @(negedge core_clk);
        chk_bit("tone_hit_a_n", 1'b0, tone_hit_a_n);
        chk_bit("tone_hit_b_n", 1'b1, tone_hit_b_n);
        tone_det_a = 1'b0;
        tone_det_b = 1'b1;
        @(negedge core_clk);
        chk_bit("tone_hit_a_n", 1'b1, tone_hit_a_n);
        chk_bit("tone_hit_b_n", 1'b0, tone_hit_b_n);
        // power-down holds reset with a detector still active
        power_down_n = 1'b0;
        settle();
        chk_bit("core_reset_n", 1'b0, core_reset_n);
        chk_bit("standby", 1'b1, standby);
        chk_bit("tone_hit_b_n", 1'b1, tone_hit_b_n);
        power_down_n = 1'b1;
        tone_det_b = 1'b0;
        settle();
        chk_bit("core_reset_n", 1'b1, core_reset_n);
        chk_bit("standby", 1'b0, standby);
        // delayed frame: bus mode pulses after slot four, strobe mode stays low
        for (m = 1; m >= 0; m--) begin
            frame_bus_mode = m[0];
            frame_in_n = 1'b0;
            @(negedge core_clk);
            frame_in_n = 1'b1;
            for (i = 1; i <= ECPC_SLOT_AFTER * ECPC_SLOT_BITS; i++) begin
                slot_bit_en = 1'b1;
                @(negedge core_clk);
                slot_bit_en = 1'b0;
                @(negedge core_clk);
                chk_bit("frame_pulse_delayed_out",
                    m[0] && (i != ECPC_SLOT_AFTER * ECPC_SLOT_BITS - 1),
                    frame_pulse_delayed_out);
            end
        end
        final_report();
    end
endmodule : echo_canceller_pin_control_tb
